// File: rtl/mcmp_defs.svh
// Offsets, field positions, limits, fault codes and timing counts of the compare unit
`ifndef MCMP_DEFS_SVH
`define MCMP_DEFS_SVH

// Register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_ENTRIES 12'h004
`define ADDR_PULSE 12'h008
`define ADDR_PATTERN 12'h00c
`define ADDR_STATUS 12'h010
`define ADDR_MATCHES 12'h014
`define ADDR_RING_LO 12'h018
`define ADDR_RING_HI 12'h01c
`define ADDR_TABLE 12'h400

// Control fields
`define CTRL_ENABLE 0
`define CTRL_HW_SEL 1
`define CTRL_CNT_LSB 4
`define CTRL_CLEAR 8
`define CTRL_RING_EXEC 9
`define CTRL_FORCE_LOW 10
`define CTRL_RING_LSB 12

// Table depth and limits
`define TABLE_DEPTH 32'h0000_0064
`define PULSE_MAX 16'h7530
`define RING_CHANNELS 3'h4

// Fault codes
`define FAULT_NONE 16'h0000
`define FAULT_CHANNEL 16'h0001
`define FAULT_NOT_ENABLED 16'h0007
`define FAULT_ENTRIES 16'h01f6
`define FAULT_PULSE 16'h01fd

// Timing
`define CLK_PERIOD_NS 4
`define PULSE_UNIT_NS 100000

`endif

// File: rtl/mcmp_pkg.sv
// Types shared by the compare unit
package mcmp_pkg;

    // Control register image
    typedef struct packed {
        logic [16:0] rsvd;
        logic [2:0] ring_sel;
        logic rsvd1;
        logic force_low;
        logic ring_exec;
        logic clear;
        logic rsvd2;
        logic [2:0] cnt_sel;
        logic [1:0] rsvd3;
        logic hw_sel;
        logic enable;
    } ctrl_t;

    // Ring limits handed to the base counter
    typedef struct packed {
        logic [3:0] enable;
        logic force_from_lower;
        logic [31:0] lower;
        logic [31:0] upper;
    } ring_cfg_t;

    // Compare sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_END = 3'b100
    } cmp_state_t;

endpackage : mcmp_pkg

// File: rtl/multi_compare_ring_counter_output.sv
// Multi-value compare unit with ring limits and coincident outputs
//
// Summary of operation
// - Table holds up to 100 compare values with an entry count up to 100.
// - Done rises when a coincident output is issued; index is reported.
// - Compare starts on enable rising edge; counter selected 0 to 7.
// - A status word reports how many matches have occurred.
// - Counting direction is frozen while compare is enabled.
// - Start count must be before the first entry or it never triggers.
// - Compare runs only while the base counter of that channel runs.
// - Software output has latency and pulse time up to 3,000 ms.
// - Software output with pulse time zero holds until cleared.
// - Hardware output drives the pattern at once for pulse time.
// - Pulse time counts in 100 us units, at most 3,000 ms.
// - Loaded compare values survive every reset.
// - Ring only on counters 0 to 3; execute rising edge loads limits.
// - Ring wraps count between signed 32-bit lower and upper limits.
// - Force-from-lower restarts at lower limit, then completion shows.
// - Output clear drops only the software output, not hardware output.
// - Software output is not driven while hardware mode is selected.
// - Entry count outside 1 to 100 gives an error.
// - Pulse time above 30000 gives an error.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mcmp_defs.svh"

module multi_compare_ring_counter_output #(
    parameter int UNIT_CYCLES = `PULSE_UNIT_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Base counters
    input wire logic [7:0][31:0] count_value,
    input wire logic [7:0] counter_active,
    input wire logic [7:0] counter_reverse,
    output logic direction_lock,
    // Ring limits to the base counters
    output mcmp_pkg::ring_cfg_t ring_cfg,
    // Coincident outputs
    output logic [7:0] cmp_out,
    output logic cmp_out_en,
    output logic [7:0] direct_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    mcmp_pkg::ctrl_t ctrl;
    mcmp_pkg::cmp_state_t state;
    logic [31:0] compare_table [0:99];
    logic [31:0] entries;
    logic [15:0] pulse_time;
    logic [7:0] pattern;
    logic [31:0] match_total;
    logic [31:0] ring_lower_limit;
    logic [31:0] ring_upper_limit;
    logic [15:0] fault_code;
    logic fault;
    logic done;
    logic ring_done;
    logic [6:0] index;
    logic [2:0] run_sel;
    logic run_reverse;
    logic run_hw;
    logic skip_first;
    logic enable_q;
    logic ring_exec_q;
    logic hit_d;
    logic tmr_on;
    logic [15:0] tmr_units;
    logic [31:0] tmr_presc;
    logic wr_en;
    logic start;
    logic hit;
    logic tmr_expire;
    logic [31:0] target;
    logic [31:0] cur_count;

    // Word index of a table address
    function automatic logic [6:0] table_index(input logic [11:0] a);
        logic [11:0] off;
        off = a - `ADDR_TABLE;
        return off[8:2];
    endfunction : table_index

    // Address falls inside the table window
    function automatic logic is_table(input logic [11:0] a);
        return (a >= `ADDR_TABLE) && ({20'h0, table_index(a)} <
            `TABLE_DEPTH) && (a[1:0] == 2'h0) && (a < 12'h600);
    endfunction : is_table

    // Signed position test: count has reached the target
    function automatic logic reached(input logic [31:0] c,
        input logic [31:0] t, input logic rev);
        return rev ? ($signed(c) <= $signed(t)) : ($signed(c) >= $signed(t));
    endfunction : reached

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and event detection
    assign wr_en = psel && penable && pready && pwrite;
    assign start = ctrl.enable && !enable_q;
    assign cur_count = count_value[run_sel];
    assign target = compare_table[index];
    assign hit = (state == mcmp_pkg::ST_RUN) && ctrl.enable &&
        counter_active[run_sel] && !(skip_first && index == 7'h00) &&
        reached(cur_count, target, run_reverse);
    assign tmr_expire = tmr_on && (tmr_units == 16'h0000);

    // APB answer prepared in setup, valid through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable)
            begin
                case (paddr)
                    `ADDR_CTRL: prdata <= ctrl;
                    `ADDR_ENTRIES: prdata <= entries;
                    `ADDR_PULSE: prdata <= {16'h0000, pulse_time};
                    `ADDR_PATTERN: prdata <= {24'h000000, pattern};
                    `ADDR_STATUS: prdata <= {fault_code, 1'b0, index,
                        5'h00, ring_done, fault, done};
                    `ADDR_MATCHES: prdata <= match_total;
                    `ADDR_RING_LO: prdata <= ring_lower_limit;
                    `ADDR_RING_HI: prdata <= ring_upper_limit;
                    default:
                    begin
                        if (is_table(paddr))
                            prdata <= compare_table[table_index(paddr)];
                        else
                            pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Configuration registers; the clear bit self-clears, the execute bit does not
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= '0;
            entries <= 32'h0000_0000;
            pulse_time <= 16'h0000;
            pattern <= 8'h00;
            ring_lower_limit <= 32'h0000_0000;
            ring_upper_limit <= 32'h0000_0000;
        end
        else
        begin
            ctrl.clear <= 1'b0;
            if (wr_en)
            begin
                case (paddr)
                    `ADDR_CTRL: ctrl <= pwdata;
                    `ADDR_ENTRIES: entries <= pwdata;
                    `ADDR_PULSE: pulse_time <= pwdata[15:0];
                    `ADDR_PATTERN: pattern <= pwdata[7:0];
                    `ADDR_RING_LO: ring_lower_limit <= pwdata;
                    `ADDR_RING_HI: ring_upper_limit <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // Compare table, no reset so values survive every reset
    always_ff @(posedge pclk)
    begin
        if (wr_en && is_table(paddr))
            compare_table[table_index(paddr)] <= pwdata;
    end

    // Edge history of the command bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= 1'b0;
            ring_exec_q <= 1'b0;
        end
        else
        begin
            enable_q <= ctrl.enable;
            ring_exec_q <= ctrl.ring_exec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= mcmp_pkg::ST_IDLE;
            index <= 7'h00;
            run_sel <= 3'h0;
            run_reverse <= 1'b0;
            run_hw <= 1'b0;
            skip_first <= 1'b0;
            done <= 1'b0;
            match_total <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                mcmp_pkg::ST_IDLE:
                begin
                    if (start && entries >= 32'h1 &&
                        entries <= `TABLE_DEPTH &&
                        pulse_time <= `PULSE_MAX &&
                        counter_active[ctrl.cnt_sel])
                    begin
                        state <= mcmp_pkg::ST_RUN;
                        index <= 7'h00;
                        run_sel <= ctrl.cnt_sel;
                        run_reverse <= counter_reverse[ctrl.cnt_sel];
                        run_hw <= ctrl.hw_sel;
                        skip_first <= reached(count_value[ctrl.cnt_sel],
                            compare_table[0],
                            counter_reverse[ctrl.cnt_sel]);
                        done <= 1'b0;
                        match_total <= 32'h0000_0000;
                    end
                end
                mcmp_pkg::ST_RUN:
                begin
                    if (!ctrl.enable || !counter_active[run_sel])
                        state <= mcmp_pkg::ST_IDLE;
                    else if (hit)
                    begin
                        done <= 1'b1;
                        match_total <= match_total + 32'h1;
                        if ({25'h0, index} == entries - 32'h1)
                            state <= mcmp_pkg::ST_END;
                        else
                            index <= index + 7'h01;
                    end
                end
                mcmp_pkg::ST_END:
                begin
                    if (!ctrl.enable)
                        state <= mcmp_pkg::ST_IDLE;
                end
                default: state <= mcmp_pkg::ST_IDLE;
            endcase
        end
    end

    // Fault reporting, updated at each start attempt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault <= 1'b0;
            fault_code <= `FAULT_NONE;
        end
        else if (start && state == mcmp_pkg::ST_IDLE)
        begin
            fault <= 1'b1;
            if (entries < 32'h1 || entries > `TABLE_DEPTH)
                fault_code <= `FAULT_ENTRIES;
            else if (pulse_time > `PULSE_MAX)
                fault_code <= `FAULT_PULSE;
            else if (!counter_active[ctrl.cnt_sel])
                fault_code <= `FAULT_NOT_ENABLED;
            else
            begin
                fault <= 1'b0;
                fault_code <= `FAULT_NONE;
            end
        end
        else if (ctrl.ring_exec && !ring_exec_q)
        begin
            fault <= (ctrl.ring_sel >= `RING_CHANNELS);
            fault_code <= (ctrl.ring_sel >= `RING_CHANNELS) ?
                `FAULT_CHANNEL : `FAULT_NONE;
        end
    end

    // Direction lock towards the base counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            direction_lock <= 1'b0;
        else
            direction_lock <= ctrl.enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring limit loading
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_cfg <= '0;
            ring_done <= 1'b0;
        end
        else
        begin
            ring_cfg.force_from_lower <= 1'b0;
            ring_done <= ring_cfg.force_from_lower || (ring_done &&
                !(ctrl.ring_exec && !ring_exec_q));
            if (ctrl.ring_exec && !ring_exec_q &&
                ctrl.ring_sel < `RING_CHANNELS)
            begin
                ring_cfg.enable[ctrl.ring_sel[1:0]] <= 1'b1;
                ring_cfg.lower <= ring_lower_limit;
                ring_cfg.upper <= ring_upper_limit;
                ring_cfg.force_from_lower <= ctrl.force_low;
                if (!ctrl.force_low)
                    ring_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse timer in 100 us units
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hit_d <= 1'b0;
            tmr_on <= 1'b0;
            tmr_units <= 16'h0000;
            tmr_presc <= 32'h0000_0000;
        end
        else
        begin
            hit_d <= hit && !run_hw;
            if ((hit && run_hw) || hit_d)
            begin
                tmr_on <= run_hw || (pulse_time != 16'h0000);
                tmr_units <= pulse_time;
                tmr_presc <= 32'h0000_0000;
            end
            else if (tmr_expire)
                tmr_on <= 1'b0;
            else if (tmr_on)
            begin
                if (tmr_presc == 32'(UNIT_CYCLES - 1))
                begin
                    tmr_presc <= 32'h0000_0000;
                    tmr_units <= tmr_units - 16'h0001;
                end
                else
                    tmr_presc <= tmr_presc + 32'h1;
            end
        end
    end

    // Coincident output drivers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_out <= 8'h00;
            cmp_out_en <= 1'b1;
            direct_out <= 8'h00;
        end
        else
        begin
            cmp_out_en <= !ctrl.hw_sel;
            if (hit && run_hw)
                direct_out <= pattern;
            else if (tmr_expire && run_hw)
                direct_out <= 8'h00;
            if (hit_d)
                cmp_out <= pattern;
            else if (ctrl.clear || (tmr_expire && !run_hw))
                cmp_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_done_on_hit;
        @(posedge pclk) disable iff (!presetn)
        hit |=> done && match_total == $past(match_total) + 32'h1;
    endproperty
    a_done_on_hit: assert property (p_done_on_hit)
        else $error("match did not set done and count");

    property p_start_needs_active;
        @(posedge pclk) disable iff (!presetn)
        (state == mcmp_pkg::ST_IDLE) ##1 (state == mcmp_pkg::ST_RUN) |->
        $past(counter_active[ctrl.cnt_sel]);
    endproperty
    a_start_needs_active: assert property (p_start_needs_active)
        else $error("compare started on idle counter");

    property p_bad_entries;
        @(posedge pclk) disable iff (!presetn)
        start && state == mcmp_pkg::ST_IDLE && entries > `TABLE_DEPTH |=>
        fault && fault_code == `FAULT_ENTRIES && state == mcmp_pkg::ST_IDLE;
    endproperty
    a_bad_entries: assert property (p_bad_entries)
        else $error("bad entry count not flagged");

    property p_bad_pulse;
        @(posedge pclk) disable iff (!presetn)
        start && state == mcmp_pkg::ST_IDLE && entries >= 32'h1 &&
        entries <= `TABLE_DEPTH && pulse_time > `PULSE_MAX |=>
        fault && fault_code == `FAULT_PULSE;
    endproperty
    a_bad_pulse: assert property (p_bad_pulse)
        else $error("bad pulse time not flagged");

    property p_hw_immediate;
        @(posedge pclk) disable iff (!presetn)
        hit && run_hw |=> direct_out == $past(pattern);
    endproperty
    a_hw_immediate: assert property (p_hw_immediate)
        else $error("direct output late");

    property p_sw_latency;
        @(posedge pclk) disable iff (!presetn)
        hit && !run_hw |=> ##1 cmp_out == $past(pattern, 2);
    endproperty
    a_sw_latency: assert property (p_sw_latency)
        else $error("software output wrong");

    property p_sw_hold;
        @(posedge pclk) disable iff (!presetn)
        cmp_out != 8'h00 && pulse_time == 16'h0000 && !run_hw &&
        !ctrl.clear && !hit_d |=> $stable(cmp_out);
    endproperty
    a_sw_hold: assert property (p_sw_hold)
        else $error("held output dropped without clear");

    property p_clear_only_sw;
        @(posedge pclk) disable iff (!presetn)
        ctrl.clear && !hit_d && !(hit && run_hw) && !tmr_expire |=>
        cmp_out == 8'h00 && direct_out == $past(direct_out);
    endproperty
    a_clear_only_sw: assert property (p_clear_only_sw)
        else $error("clear misbehaved");

    property p_oe_off_hw;
        @(posedge pclk) disable iff (!presetn)
        ctrl.hw_sel |=> !cmp_out_en;
    endproperty
    a_oe_off_hw: assert property (p_oe_off_hw)
        else $error("software output driven in hardware mode");

    property p_stop_after_last;
        @(posedge pclk) disable iff (!presetn)
        state == mcmp_pkg::ST_END |-> !hit ##1 $stable(match_total);
    endproperty
    a_stop_after_last: assert property (p_stop_after_last)
        else $error("match after last entry");

    property p_ring_channel;
        @(posedge pclk) disable iff (!presetn)
        ctrl.ring_exec && !ring_exec_q && ctrl.ring_sel >= `RING_CHANNELS |=>
        fault_code == `FAULT_CHANNEL && $stable(ring_cfg.enable);
    endproperty
    a_ring_channel: assert property (p_ring_channel)
        else $error("ring accepted on bad channel");

    property p_force_done;
        @(posedge pclk) disable iff (!presetn)
        ring_cfg.force_from_lower |=> ring_done;
    endproperty
    a_force_done: assert property (p_force_done)
        else $error("force load not completed");

    c_hw_match: cover property (@(posedge pclk) disable iff (!presetn)
        hit && run_hw);
    c_sw_match: cover property (@(posedge pclk) disable iff (!presetn)
        hit_d ##[1:20] ctrl.clear);
    c_run_end: cover property (@(posedge pclk) disable iff (!presetn)
        state == mcmp_pkg::ST_END);
    c_ring_force: cover property (@(posedge pclk) disable iff (!presetn)
        ring_cfg.force_from_lower);

endmodule : multi_compare_ring_counter_output
`default_nettype wire

// File: dv/cnt_model.sv
// Behavioural base counters standing behind the compare unit
`timescale 1ns/10ps
`default_nettype none
module cnt_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Test control
    input wire logic load,
    input wire logic [7:0] run,
    input wire logic [7:0] rev_req,
    input wire logic direction_lock,
    // Counter side
    output logic [7:0][31:0] count_value,
    output logic [7:0] counter_active,
    output logic [7:0] counter_reverse
);
    // Direction requests are held off while compare owns the direction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_reverse <= 8'h00;
        else if (!direction_lock)
            counter_reverse <= rev_req;
    end
    // Channel run flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_active <= 8'h00;
        else
            counter_active <= run;
    end
    // Running channels step once a cycle; load parks all below the table
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value <= '0;
        else
            for (int i = 0; i < 8; i++)
            begin
                if (load)
                    count_value[i] <= 32'h0000_0000;
                else if (counter_active[i])
                    count_value[i] <= counter_reverse[i] ?
                        count_value[i] - 32'h1 : count_value[i] + 32'h1;
            end
    end
endmodule : cnt_model
`default_nettype wire

// File: dv/multi_compare_ring_counter_output_test.sv
// Self-checking bench for the multi-value compare unit
`timescale 1ns/10ps
`default_nettype none
`include "mcmp_defs.svh"
module multi_compare_ring_counter_output_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic load = 1'b0;
    logic [7:0] run = 8'h04;
    logic [7:0] rev_req = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, direction_lock, cmp_out_en;
    logic [7:0] cmp_out, direct_out, counter_active, counter_reverse;
    logic [7:0] last_do = 8'h00;
    logic [7:0][31:0] count_value;
    mcmp_pkg::ring_cfg_t ring_cfg;
    logic [32:0] rq_val[$];
    logic [32:0] rq_msk[$];
    logic [32:0] m;
    logic [7:0] dq[$];
    logic [31:0] tbl[100];
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int force_seen = 0;
    int do_len = 0;
    int fe[4] = '{0, 101, 100, 3};
    int fp[4] = '{0, 0, 30001, 0};
    int fs[4] = '{2, 2, 2, 5};
    int fc[4] = '{32'h1f6, 32'h1f6, 32'h1fd, 32'h007};

    always #2 pclk = ~pclk;

    multi_compare_ring_counter_output #(.UNIT_CYCLES(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_value(count_value),
        .counter_active(counter_active), .counter_reverse(counter_reverse),
        .direction_lock(direction_lock), .ring_cfg(ring_cfg),
        .cmp_out(cmp_out), .cmp_out_en(cmp_out_en), .direct_out(direct_out));
    cnt_model far (
        .pclk(pclk), .presetn(presetn), .load(load), .run(run),
        .rev_req(rev_req), .direction_lock(direction_lock),
        .count_value(count_value), .counter_active(counter_active),
        .counter_reverse(counter_reverse));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [32:0] e,
                       input logic [32:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] mk, input logic err);
        repeat (2) @(posedge pclk);
        rq_val.push_back({err, e});
        rq_msk.push_back({1'b1, mk});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse_load;
        @(posedge pclk);
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
    endtask : pulse_load

    ////////////////////////////////////////////////////////////////////////
    // Watcher: read answers and hardware output pulses against the notes
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            m = rq_msk.size() > 0 ? rq_msk.pop_front() : 33'h0;
            chk("read", rq_val.size() > 0 ? rq_val.pop_front() : 33'hx,
                {pslverr, prdata} & m);
        end
        if (direct_out !== 8'h00 && last_do === 8'h00)
            chk("direct_out", dq.size() > 0 ? {25'h0, dq.pop_front()} : 33'hx,
                {25'h0, direct_out});
        if (ring_cfg.force_from_lower === 1'b1)
            force_seen++;
        if (direct_out !== 8'h00)
            do_len++;
        last_do <= direct_out;
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] v;
        logic [7:0] pat;
        v = $urandom(32'h7c01);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_CTRL, 32'h0, '1, 1'b0);
        rd(`ADDR_STATUS, 32'h0, '1, 1'b0);
        rd(12'h020, 32'h0, '1, 1'b1);
        chk("cmp_out_en", 33'h1, {32'h0, cmp_out_en});
        for (int i = 0; i < 100; i++)
        begin
            v = $urandom;
            if (v == 32'h8000_0000 || v == 32'h7fff_ffff)
                v = 32'h0;
            tbl[i] = v;
            wr(`ADDR_TABLE + 12'(4 * i), v);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 100; i++)
            rd(`ADDR_TABLE + 12'(4 * i), tbl[i], '1, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADDR_ENTRIES, 32'(fe[i]));
            wr(`ADDR_PULSE, 32'(fp[i]));
            wr(`ADDR_CTRL, 32'h0);
            wr(`ADDR_CTRL, 32'(fs[i] * 16 + 1));
            rd(`ADDR_STATUS, 32'(fc[i] * 65536 + 2), 32'hffff_0002, 1'b0);
        end
        // Hardware direct output, three ascending entries
        for (int i = 0; i < 3; i++)
            wr(`ADDR_TABLE + 12'(4 * i), 32'(100 + 20 * i));
        pat = 8'($urandom_range(1, 255));
        wr(`ADDR_ENTRIES, 32'd3);
        wr(`ADDR_PULSE, 32'd1);
        wr(`ADDR_PATTERN, {24'h0, pat});
        wr(`ADDR_CTRL, 32'h0);
        pulse_load();
        wr(`ADDR_CTRL, 32'h23);
        repeat (3) dq.push_back(pat);
        // Direction request only once the lock is up
        @(posedge pclk);
        rev_req <= 8'hff;
        repeat (200) @(posedge pclk);
        chk("pulse cycles", 33'd15, 33'(do_len));
        chk("direction_lock", 33'h1, {32'h0, direction_lock});
        chk("cmp_out_en", 33'h0, {32'h0, cmp_out_en});
        rd(`ADDR_STATUS, 32'h1, 32'hffff_0003, 1'b0);
        rd(`ADDR_MATCHES, 32'd3, '1, 1'b0);
        // Software output with zero pulse time holds until cleared
        rev_req <= 8'h00;
        wr(`ADDR_CTRL, 32'h0);
        wr(`ADDR_PULSE, 32'h0);
        pulse_load();
        wr(`ADDR_CTRL, 32'h21);
        repeat (200) @(posedge pclk);
        chk("cmp_out held", {25'h0, pat}, {25'h0, cmp_out});
        wr(`ADDR_CTRL, 32'h121);
        repeat (4) @(posedge pclk);
        chk("cmp_out cleared", 33'h0, {25'h0, cmp_out});
        // Ring limits with forced restart, then a channel without ring
        v = $urandom_range(0, 1000);
        wr(`ADDR_RING_LO, v);
        wr(`ADDR_RING_HI, v + 32'd5000);
        wr(`ADDR_CTRL, 32'h0);
        wr(`ADDR_CTRL, 32'h1600);
        repeat (3) @(posedge pclk);
        chk("ring lower", {1'b0, v}, {1'b0, ring_cfg.lower});
        chk("ring upper", {1'b0, v + 32'd5000}, {1'b0, ring_cfg.upper});
        chk("force pulses", 33'h1, 33'(force_seen));
        rd(`ADDR_STATUS, 32'h4, 32'h4, 1'b0);
        wr(`ADDR_CTRL, 32'h0);
        wr(`ADDR_CTRL, 32'h5200);
        rd(`ADDR_STATUS, 32'h0001_0002, 32'hffff_0002, 1'b0);
        chk("ring enable", 33'h2, {29'h0, ring_cfg.enable});
        chk("pending pulses", 33'h0, 33'(dq.size()));
        report_and_stop();
    end
endmodule : multi_compare_ring_counter_output_test
`default_nettype wire
